// >>> design/sdram_bank_power.sv
/*
  Command acceptance, per-bank state and power-down control of a low-power
  synchronous DRAM. Pin logic runs on the memory clock, except that CKE high
  clears deep power-down with no clock edge; power status is carried into
  the system clock domain.
  Assumes the controller drives all pins other than CKE synchronous to mem_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module sdram_bank_power #(
  parameter int NUM_BANKS = 4,
  parameter int BURST_LEN = sdram_pkg::BURST_LEN
) (
  // system side
  input wire logic clk_i,
  input wire logic rst_i,
  // memory pins
  input wire logic mem_clk_i,
  input wire logic cke_i,
  input wire logic cs_n_i,
  input wire logic ras_n_i,
  input wire logic cas_n_i,
  input wire logic we_n_i,
  input wire logic [$clog2(NUM_BANKS)-1:0] ba_i,
  input wire logic a10_i,
  // memory clock status
  output logic buffers_on_o,
  output logic cmd_taken_o,
  output logic cmd_refused_o,
  output logic [NUM_BANKS-1:0] bank_open_o,
  // system clock status
  output logic pd_precharge_o,
  output logic pd_active_o,
  output logic self_refresh_o,
  output logic deep_pd_o,
  output logic all_idle_o
);
  localparam int BW = $clog2(NUM_BANKS);
  localparam int TW = sdram_pkg::TIMER_W;
  localparam logic [TW-1:0] T_RP = TW'(sdram_pkg::PRECHARGE_PERIOD_CYC);
  localparam logic [TW-1:0] T_RC = TW'(sdram_pkg::ROW_CYCLE_PERIOD_CYC);
  localparam logic [TW-1:0] T_RCD = TW'(sdram_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC);
  localparam logic [TW-1:0] T_MRD = TW'(sdram_pkg::MODE_SET_DELAY_CYC);
  localparam logic [TW-1:0] T_BURST = TW'(BURST_LEN);
  localparam int ACT_DLY = sdram_pkg::ACTIVATE_TO_ACCESS_DELAY_CYC;

  typedef sdram_pkg::bank_state_t bank_t;

  // ****************************************
  // command decode
  // ****************************************
  sdram_pkg::cmd_t cmd;
  logic is_nop;
  assign cmd = sdram_pkg::decode_cmd(cs_n_i, {ras_n_i, cas_n_i, we_n_i});
  assign is_nop = (cmd == sdram_pkg::CMD_NOP) || (cmd == sdram_pkg::CMD_DESELECT);

  function automatic logic in_burst(input bank_t s);
    return (s == sdram_pkg::BANK_READ) || (s == sdram_pkg::BANK_WRITE);
  endfunction

  function automatic logic auto_burst(input bank_t s);
    return (s == sdram_pkg::BANK_READ_AUTO) || (s == sdram_pkg::BANK_WRITE_AUTO);
  endfunction

  // states that may take a precharge; idle and precharging treat it as NOP
  function automatic logic can_precharge(input bank_t s);
    return (s == sdram_pkg::BANK_IDLE) || (s == sdram_pkg::BANK_ROW_ACTIVE) ||
           in_burst(s) || (s == sdram_pkg::BANK_PRECHARGING);
  endfunction

  // ****************************************
  // state
  // ****************************************
  bank_t bank_q [NUM_BANKS];
  bank_t bank_d [NUM_BANKS];
  logic [TW-1:0] tmr_q [NUM_BANKS];
  logic [TW-1:0] tmr_d [NUM_BANKS];
  logic [TW-1:0] gbusy_q;
  logic [TW-1:0] gbusy_d;
  logic [BW-1:0] last_bank_q;
  logic cke_prev_q;
  logic deep_q;
  logic taken_q;
  logic refused_q;
  logic [NUM_BANKS-1:0] open_q;
  sdram_pkg::power_state_t pwr_q;
  sdram_pkg::power_state_t pwr_d;

  logic all_idle;
  logic any_burst;
  logic can_pre_all;
  logic run_ok;
  logic legal;
  logic go;
  logic pd_enter;
  logic deep_enter;
  logic sref_enter;

  always_comb begin
    all_idle = 1'b1;
    any_burst = 1'b0;
    can_pre_all = 1'b1;
    for (int b = 0; b < NUM_BANKS; b++) begin
      if (bank_q[b] != sdram_pkg::BANK_IDLE) begin
        all_idle = 1'b0;
      end
      if (in_burst(bank_q[b]) || auto_burst(bank_q[b])) begin
        any_burst = 1'b1;
      end
      if (!can_precharge(bank_q[b])) begin
        can_pre_all = 1'b0;
      end
    end
  end

  // ****************************************
  // command acceptance
  // ****************************************
  // bank rules hold only with CKE high on this and the previous edge
  assign run_ok = cke_prev_q && cke_i && (pwr_q == sdram_pkg::PWR_RUN) &&
                  !deep_q && (gbusy_q == '0);

  always_comb begin
    legal = 1'b0;
    unique case (cmd)
      sdram_pkg::CMD_ACTIVE: legal = (bank_q[ba_i] == sdram_pkg::BANK_IDLE);
      sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE:
        legal = (bank_q[ba_i] == sdram_pkg::BANK_ROW_ACTIVE) || in_burst(bank_q[ba_i]);
      sdram_pkg::CMD_PRECHARGE:
        legal = a10_i ? can_pre_all : can_precharge(bank_q[ba_i]);
      sdram_pkg::CMD_BURST_STOP: legal = in_burst(bank_q[last_bank_q]);
      sdram_pkg::CMD_REFRESH, sdram_pkg::CMD_MODE_SET: legal = all_idle;
      default: legal = 1'b0;
    endcase
  end

  assign go = run_ok && !is_nop && legal;

  // ****************************************
  // bank state and timers
  // ****************************************
  always_comb begin
    for (int b = 0; b < NUM_BANKS; b++) begin
      bank_d[b] = bank_q[b];
      tmr_d[b] = (tmr_q[b] != '0) ? tmr_q[b] - TW'(1) : '0;
      // timer runs out: the bank moves on by itself
      if (tmr_q[b] == TW'(1)) begin
        unique case (bank_q[b])
          sdram_pkg::BANK_ACTIVATING, sdram_pkg::BANK_READ, sdram_pkg::BANK_WRITE:
            bank_d[b] = sdram_pkg::BANK_ROW_ACTIVE;
          sdram_pkg::BANK_READ_AUTO, sdram_pkg::BANK_WRITE_AUTO: begin
            bank_d[b] = sdram_pkg::BANK_PRECHARGING;
            tmr_d[b] = T_RP;
          end
          sdram_pkg::BANK_PRECHARGING: bank_d[b] = sdram_pkg::BANK_IDLE;
          sdram_pkg::BANK_IDLE, sdram_pkg::BANK_ROW_ACTIVE: bank_d[b] = bank_q[b];
        endcase
      end
      if (go) begin
        unique case (cmd)
          sdram_pkg::CMD_ACTIVE: begin
            if (BW'(b) == ba_i) begin
              bank_d[b] = sdram_pkg::BANK_ACTIVATING;
              tmr_d[b] = T_RCD;
            end
          end
          sdram_pkg::CMD_READ, sdram_pkg::CMD_WRITE: begin
            if (BW'(b) == ba_i) begin
              if (cmd == sdram_pkg::CMD_READ) begin
                bank_d[b] = a10_i ? sdram_pkg::BANK_READ_AUTO : sdram_pkg::BANK_READ;
              end else begin
                bank_d[b] = a10_i ? sdram_pkg::BANK_WRITE_AUTO : sdram_pkg::BANK_WRITE;
              end
              tmr_d[b] = T_BURST;
            end else if (in_burst(bank_q[b])) begin
              bank_d[b] = sdram_pkg::BANK_ROW_ACTIVE;
              tmr_d[b] = '0;
            end else if (auto_burst(bank_q[b])) begin
              bank_d[b] = sdram_pkg::BANK_PRECHARGING;
              tmr_d[b] = T_RP;
            end
          end
          sdram_pkg::CMD_PRECHARGE: begin
            // idle or already precharging banks take it as a NOP
            if ((a10_i || BW'(b) == ba_i) &&
                ((bank_q[b] == sdram_pkg::BANK_ROW_ACTIVE) || in_burst(bank_q[b]))) begin
              bank_d[b] = sdram_pkg::BANK_PRECHARGING;
              tmr_d[b] = T_RP;
            end
          end
          sdram_pkg::CMD_BURST_STOP: begin
            if (BW'(b) == last_bank_q) begin
              bank_d[b] = sdram_pkg::BANK_ROW_ACTIVE;
              tmr_d[b] = '0;
            end
          end
          default: bank_d[b] = bank_d[b];
        endcase
      end
    end
  end

  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_q[b] <= sdram_pkg::BANK_IDLE;
        tmr_q[b] <= '0;
      end
    end else begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        bank_q[b] <= bank_d[b];
        tmr_q[b] <= tmr_d[b];
      end
    end
  end

  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_bank_q <= '0;
    end else if (go && (cmd == sdram_pkg::CMD_READ || cmd == sdram_pkg::CMD_WRITE)) begin
      last_bank_q <= ba_i;
    end
  end

  // ****************************************
  // global busy timer
  // ****************************************
  always_comb begin
    gbusy_d = (gbusy_q != '0) ? gbusy_q - TW'(1) : '0;
    if (go && cmd == sdram_pkg::CMD_REFRESH) begin
      gbusy_d = T_RC;
    end else if (go && cmd == sdram_pkg::CMD_MODE_SET) begin
      gbusy_d = T_MRD;
    end else if (go && cmd == sdram_pkg::CMD_PRECHARGE && a10_i) begin
      gbusy_d = T_RP;
    end else if (pwr_q == sdram_pkg::PWR_SELF_REFRESH && cke_i) begin
      gbusy_d = T_RC;
    end
  end

  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      gbusy_q <= '0;
    end else begin
      gbusy_q <= gbusy_d;
    end
  end

  // ****************************************
  // power state
  // ****************************************
  // CKE falling edge seen on a run edge; entry kind by the command beside it
  assign deep_enter = cke_prev_q && !cke_i && (pwr_q == sdram_pkg::PWR_RUN) && !deep_q &&
                      (cmd == sdram_pkg::CMD_BURST_STOP) && all_idle;
  assign sref_enter = cke_prev_q && !cke_i && (pwr_q == sdram_pkg::PWR_RUN) && !deep_q &&
                      (cmd == sdram_pkg::CMD_REFRESH) && all_idle && (gbusy_q == '0);
  // clock suspend during a burst is not modelled: the drop is refused
  assign pd_enter = cke_prev_q && !cke_i && (pwr_q == sdram_pkg::PWR_RUN) && !deep_q &&
                    is_nop && !any_burst;

  always_comb begin
    pwr_d = pwr_q;
    unique case (pwr_q)
      sdram_pkg::PWR_RUN: begin
        if (sref_enter) begin
          pwr_d = sdram_pkg::PWR_SELF_REFRESH;
        end else if (pd_enter) begin
          pwr_d = all_idle ? sdram_pkg::PWR_PD_PRECHARGE : sdram_pkg::PWR_PD_ACTIVE;
        end
      end
      sdram_pkg::PWR_PD_PRECHARGE, sdram_pkg::PWR_PD_ACTIVE, sdram_pkg::PWR_SELF_REFRESH: begin
        if (cke_i) begin
          pwr_d = sdram_pkg::PWR_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_q <= sdram_pkg::PWR_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // CKE high clears deep power-down with no clock edge
  always_ff @(posedge mem_clk_i or posedge rst_i or posedge cke_i) begin
    if (rst_i || cke_i) begin
      deep_q <= 1'b0;
    end else if (deep_enter) begin
      deep_q <= 1'b1;
    end
  end

  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cke_prev_q <= 1'b0;
    end else begin
      cke_prev_q <= cke_i;
    end
  end

  // ****************************************
  // memory clock outputs
  // ****************************************
  always_ff @(posedge mem_clk_i or posedge rst_i) begin
    if (rst_i) begin
      taken_q <= 1'b0;
      refused_q <= 1'b0;
      open_q <= '0;
    end else begin
      taken_q <= go || deep_enter || sref_enter;
      refused_q <= !is_nop && !go && !deep_enter && !sref_enter;
      for (int b = 0; b < NUM_BANKS; b++) begin
        open_q[b] <= (bank_d[b] != sdram_pkg::BANK_IDLE);
      end
    end
  end

  assign buffers_on_o = (pwr_q == sdram_pkg::PWR_RUN) && !deep_q;
  assign cmd_taken_o = taken_q;
  assign cmd_refused_o = refused_q;
  assign bank_open_o = open_q;

  // ****************************************
  // system clock status
  // ****************************************
  // each bit a slow independent level, so per-bit flops suffice
  logic [4:0] status_link;
  logic [4:0] status_sys;
  assign status_link = {pwr_q == sdram_pkg::PWR_PD_PRECHARGE, pwr_q == sdram_pkg::PWR_PD_ACTIVE,
                        pwr_q == sdram_pkg::PWR_SELF_REFRESH, deep_q, all_idle};

  level_sync #(
    .WIDTH(5)
  ) u_status_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(status_link),
    .q_o(status_sys)
  );

  assign pd_precharge_o = status_sys[4];
  assign pd_active_o = status_sys[3];
  assign self_refresh_o = status_sys[2];
  assign deep_pd_o = status_sys[1];
  assign all_idle_o = status_sys[0];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mem_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_cke_drop;
    cke_prev_q && !cke_i && pwr_q == sdram_pkg::PWR_RUN && !deep_q;
  endsequence

  sequence s_open_bank0;
    go && cmd == sdram_pkg::CMD_ACTIVE && ba_i == '0;
  endsequence

  pd_entry_a: assert property (s_cke_drop and (is_nop && !any_burst) |=>
    (pwr_q == sdram_pkg::PWR_PD_PRECHARGE || pwr_q == sdram_pkg::PWR_PD_ACTIVE))
    else $error("power-down not entered on CKE low");

  pd_kind_a: assert property ($rose(pwr_q == sdram_pkg::PWR_PD_PRECHARGE) |->
    $past(all_idle)) else $error("precharge power-down with open bank");

  buffers_off_a: assert property (pwr_q != sdram_pkg::PWR_RUN |-> !buffers_on_o)
    else $error("buffers on during power-down");

  pd_exit_a: assert property ((pwr_q == sdram_pkg::PWR_PD_PRECHARGE ||
    pwr_q == sdram_pkg::PWR_PD_ACTIVE) && cke_i |=> pwr_q == sdram_pkg::PWR_RUN ##1
    buffers_on_o || !cke_prev_q) else $error("power-down exit late");

  deep_entry_a: assert property (s_cke_drop and (cmd == sdram_pkg::CMD_BURST_STOP && all_idle)
    |=> deep_q && !buffers_on_o) else $error("deep power-down not entered");

  act_delay_a: assert property (s_open_bank0 |=>
    bank_q[0] == sdram_pkg::BANK_ACTIVATING ##(ACT_DLY) bank_q[0] == sdram_pkg::BANK_ROW_ACTIVE)
    else $error("activate delay wrong");

  cke_gate_a: assert property (!cke_prev_q && !is_nop |=> !cmd_taken_o)
    else $error("command taken without CKE high twice");

  busy_refuse_a: assert property (gbusy_q != '0 && !is_nop && cke_i |=>
    cmd_refused_o || cmd_taken_o && !cke_prev_q) else $error("command taken while busy");

  refresh_busy_a: assert property (go && cmd == sdram_pkg::CMD_REFRESH |=>
    gbusy_q == T_RC && all_idle) else $error("refresh busy not started");

  burst_stop_a: assert property (go && cmd == sdram_pkg::CMD_BURST_STOP |=>
    bank_q[$past(last_bank_q)] == sdram_pkg::BANK_ROW_ACTIVE) else $error("burst not stopped");

  conc_close_a: assert property (go && cmd == sdram_pkg::CMD_READ && ba_i != '0 &&
    auto_burst(bank_q[0]) |=> bank_q[0] == sdram_pkg::BANK_PRECHARGING && tmr_q[0] == T_RP)
    else $error("auto-close bank did not start precharging");

  idle_pre_a: assert property (go && cmd == sdram_pkg::CMD_PRECHARGE && !a10_i &&
    ba_i == '0 && bank_q[0] == sdram_pkg::BANK_IDLE |=> bank_q[0] == sdram_pkg::BANK_IDLE)
    else $error("precharge to idle bank changed it");
endmodule
`default_nettype wire

// >>> design/sdram_pkg.sv
/*
  Shared constants and types of the bank-state and power-down logic: command
  codes, bank and power states, and timing figures turned into clock counts.
  Assumes the command pins are sampled on the memory clock and that the
  counts are taken at the memory clock rate.
*/
package sdram_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int PRECHARGE_PERIOD_NS = 19;
  localparam int ROW_CYCLE_PERIOD_NS = 67;
  // not printed with this block: plain defaults
  localparam int ACTIVATE_TO_ACCESS_DELAY_NS = 19;
  localparam int MODE_SET_DELAY_NS = 20;
  localparam int BURST_LEN = 4;
  localparam int TIMER_W = 8;

  // least times: round up, never below one cycle
  function automatic int ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) begin
      c = 1;
    end
    return c;
  endfunction

  localparam int PRECHARGE_PERIOD_CYC = ns_to_cycles(PRECHARGE_PERIOD_NS);
  localparam int ROW_CYCLE_PERIOD_CYC = ns_to_cycles(ROW_CYCLE_PERIOD_NS);
  localparam int ACTIVATE_TO_ACCESS_DELAY_CYC = ns_to_cycles(ACTIVATE_TO_ACCESS_DELAY_NS);
  localparam int MODE_SET_DELAY_CYC = ns_to_cycles(MODE_SET_DELAY_NS);

  // ****************************************
  // command pin codes {ras_n, cas_n, we_n}
  // ****************************************
  localparam logic [2:0] CODE_NOP = 3'h7;
  localparam logic [2:0] CODE_ACTIVE = 3'h3;
  localparam logic [2:0] CODE_READ = 3'h5;
  localparam logic [2:0] CODE_WRITE = 3'h4;
  localparam logic [2:0] CODE_PRECHARGE = 3'h2;
  localparam logic [2:0] CODE_BURST_STOP = 3'h6;
  localparam logic [2:0] CODE_REFRESH = 3'h1;
  localparam logic [2:0] CODE_MODE_SET = 3'h0;

  typedef enum logic [3:0] {
    CMD_DESELECT, CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE,
    CMD_PRECHARGE, CMD_BURST_STOP, CMD_REFRESH, CMD_MODE_SET
  } cmd_t;

  typedef enum logic [2:0] {
    BANK_IDLE, BANK_ACTIVATING, BANK_ROW_ACTIVE, BANK_READ, BANK_WRITE,
    BANK_READ_AUTO, BANK_WRITE_AUTO, BANK_PRECHARGING
  } bank_state_t;

  typedef enum logic [1:0] {
    PWR_RUN, PWR_PD_PRECHARGE, PWR_PD_ACTIVE, PWR_SELF_REFRESH
  } power_state_t;

  function automatic cmd_t decode_cmd(input logic cs_n, input logic [2:0] code);
    cmd_t c;
    c = CMD_DESELECT;
    if (!cs_n) begin
      unique case (code)
        CODE_NOP: c = CMD_NOP;
        CODE_ACTIVE: c = CMD_ACTIVE;
        CODE_READ: c = CMD_READ;
        CODE_WRITE: c = CMD_WRITE;
        CODE_PRECHARGE: c = CMD_PRECHARGE;
        CODE_BURST_STOP: c = CMD_BURST_STOP;
        CODE_REFRESH: c = CMD_REFRESH;
        CODE_MODE_SET: c = CMD_MODE_SET;
      endcase
    end
    return c;
  endfunction

endpackage

// >>> design/level_sync.sv
/*
  Two-flop synchroniser for independent level signals.
  Assumes each bit is a slow level that may be seen one cycle apart from
  its neighbours.
*/
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;
endmodule
`default_nettype wire

// >>> verification/sdram_ctrl_model.sv
/*
  Controller model: makes the memory clock and drives CKE and command pins.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
  // memory pins
  output logic mem_clk_o,
  output logic cke_o,
  output logic cs_n_o,
  output logic [2:0] code_o,
  output logic [1:0] ba_o,
  output logic a10_o
);
  // ****************************************
  // free-running clock, odd phase
  // ****************************************
  initial begin
    mem_clk_o = 1'b0;
    #7;
    forever #32 mem_clk_o = ~mem_clk_o;
  end
  initial begin
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    code_o = 3'h7;
    ba_o = 2'h0;
    a10_o = 1'b0;
  end
  // ****************************************
  // pin tasks
  // ****************************************
  task automatic issue(input logic k, input logic [2:0] c, input logic [1:0] b, input logic a);
    @(negedge mem_clk_o);
    cke_o = k;
    cs_n_o = 1'b0;
    code_o = c;
    ba_o = b;
    a10_o = a;
    @(posedge mem_clk_o);
  endtask
  // deselected pins carry a moving pattern, never the last value
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge mem_clk_o);
      cs_n_o = 1'b1;
      code_o = ~code_o;
      ba_o = ~ba_o;
      a10_o = ~a10_o;
      @(posedge mem_clk_o);
    end
  endtask
  // raised between rising edges, so only the asynchronous path can act on it
  task automatic wake();
    @(negedge mem_clk_o);
    cke_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_sdram_bank_power.sv
/*
  Self-checking bench of sdram_bank_power with a controller model.
  Assumes NOTES latencies: one pulse per executed or refused command.
*/
`timescale 1ns/1ps
`default_nettype none
module test_sdram_bank_power;
  logic clk_i, rst_i, mem_clk, cke, cs_n, a10, buf_on, taken, refused;
  logic pd_pre, pd_act, deep, all_idle, sref;
  logic [2:0] code;
  logic [1:0] ba, b, m;
  logic [3:0] bank_open;
  logic [31:0] rng;
  logic [1:0] exp_q[$];
  int bad_count, compares;
  sdram_ctrl_model i_sdram_ctrl_model (.mem_clk_o(mem_clk), .cke_o(cke), .cs_n_o(cs_n),
    .code_o(code), .ba_o(ba), .a10_o(a10));
  sdram_bank_power i_sdram_bank_power (.clk_i(clk_i), .rst_i(rst_i), .mem_clk_i(mem_clk),
    .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(code[2]), .cas_n_i(code[1]), .we_n_i(code[0]),
    .ba_i(ba), .a10_i(a10), .buffers_on_o(buf_on), .cmd_taken_o(taken),
    .cmd_refused_o(refused), .bank_open_o(bank_open), .pd_precharge_o(pd_pre),
    .pd_active_o(pd_act), .self_refresh_o(sref), .deep_pd_o(deep), .all_idle_o(all_idle));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic final_report();
    if (bad_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check_level(input logic [4:0] got, input logic [4:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t level %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_pulse(input logic [1:0] got);
    compares++;
    if (exp_q.size() == 0 || exp_q[0] !== got) begin
      bad_count++;
      $display("[ERR] %0t answer %b unexpected", $time, got);
    end
    if (exp_q.size() > 0) void'(exp_q.pop_front());
  endtask
  // expected answer: 2'b10 taken, 2'b01 refused
  task automatic cmd(input logic [2:0] c, input logic [1:0] bk, input logic a, input logic [1:0] e);
    exp_q.push_back(e);
    i_sdram_ctrl_model.issue(1'b1, c, bk, a);
  endtask
  always @(negedge mem_clk) begin
    if (!rst_i && (taken || refused)) check_pulse({taken, refused});
  end
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #500us;
    bad_count++;
    final_report();
  end
  initial begin
    rst_i = 1'b1;
    rng = 32'h85b9783b;
    repeat (4) @(posedge clk_i);
    @(negedge clk_i);
    rst_i = 1'b0;
    i_sdram_ctrl_model.idle(2);
    rng = xs(rng);
    b = rng[1:0];
    m = b ^ 2'h1;
    cmd(sdram_pkg::CODE_ACTIVE, b, 1'b0, 2'b10);
    cmd(sdram_pkg::CODE_ACTIVE, m, 1'b0, 2'b10);
    cmd(sdram_pkg::CODE_READ, b, 1'b1, 2'b01);
    cmd(sdram_pkg::CODE_READ, b, 1'b1, 2'b10);
    // no data pins here, so there is nothing to mask on this turn
    cmd(sdram_pkg::CODE_WRITE, m, 1'b0, 2'b10);
    cmd(sdram_pkg::CODE_READ, m, 1'b0, 2'b10);
    cmd(sdram_pkg::CODE_BURST_STOP, b, 1'b0, 2'b10);
    cmd(sdram_pkg::CODE_REFRESH, b, 1'b0, 2'b01);
    #1 check_level(bank_open, 4'h1 << m);
    cmd(sdram_pkg::CODE_PRECHARGE, m, 1'b0, 2'b10);
    cmd(sdram_pkg::CODE_PRECHARGE, b, 1'b0, 2'b10);
    i_sdram_ctrl_model.idle(3);
    check_level({bank_open, all_idle}, 5'h01);
    cmd(sdram_pkg::CODE_REFRESH, b, 1'b0, 2'b10);
    cmd(sdram_pkg::CODE_ACTIVE, b, 1'b0, 2'b01);
    i_sdram_ctrl_model.idle(7);
    cmd(sdram_pkg::CODE_MODE_SET, b, 1'b0, 2'b10);
    i_sdram_ctrl_model.idle(2);
    check_level(buf_on, 4'h1);
    i_sdram_ctrl_model.issue(1'b0, sdram_pkg::CODE_NOP, b, 1'b0);
    #1 check_level(buf_on, 4'h0);
    exp_q.push_back(2'b01);
    i_sdram_ctrl_model.issue(1'b0, sdram_pkg::CODE_ACTIVE, b, 1'b0);
    i_sdram_ctrl_model.idle(3);
    check_level({pd_pre, pd_act}, 4'h2);
    i_sdram_ctrl_model.issue(1'b1, sdram_pkg::CODE_NOP, b, 1'b0);
    #1 check_level({buf_on, bank_open}, 5'h10);
    i_sdram_ctrl_model.idle(1);
    cmd(sdram_pkg::CODE_ACTIVE, m, 1'b0, 2'b10);
    i_sdram_ctrl_model.idle(3);
    i_sdram_ctrl_model.issue(1'b0, sdram_pkg::CODE_NOP, b, 1'b0);
    i_sdram_ctrl_model.idle(3);
    check_level({pd_pre, pd_act}, 4'h1);
    i_sdram_ctrl_model.issue(1'b1, sdram_pkg::CODE_NOP, b, 1'b0);
    i_sdram_ctrl_model.idle(1);
    cmd(sdram_pkg::CODE_PRECHARGE, b, 1'b1, 2'b10);
    i_sdram_ctrl_model.idle(3);
    exp_q.push_back(2'b10);
    i_sdram_ctrl_model.issue(1'b0, sdram_pkg::CODE_BURST_STOP, b, 1'b0);
    i_sdram_ctrl_model.idle(3);
    check_level(deep, 4'h1);
    i_sdram_ctrl_model.wake();
    #30 check_level(deep, 4'h0);
    i_sdram_ctrl_model.idle(3125);
    cmd(sdram_pkg::CODE_REFRESH, b, 1'b0, 2'b10);
    i_sdram_ctrl_model.idle(8);
    // refresh with CKE dropped: self refresh, exit loads the row cycle wait
    exp_q.push_back(2'b10);
    i_sdram_ctrl_model.issue(1'b0, sdram_pkg::CODE_REFRESH, b, 1'b0);
    i_sdram_ctrl_model.idle(3);
    check_level({sref, buf_on}, 5'h02);
    i_sdram_ctrl_model.issue(1'b1, sdram_pkg::CODE_NOP, b, 1'b0);
    cmd(sdram_pkg::CODE_ACTIVE, m, 1'b0, 2'b01);
    i_sdram_ctrl_model.idle(8);
    check_level({sref, buf_on}, 5'h01);
    check_level(5'(exp_q.size()), 5'h00);
    final_report();
  end
endmodule
`default_nettype wire
